// file: verilog/line_codec_defs.svh
// constants for the tactical line mode codec
`ifndef LINE_CODEC_DEFS_SVH
`define LINE_CODEC_DEFS_SVH
`define RATE_16K_BPS        32'd16
`define RATE_32K_BPS        32'd32
`define CLK_HZ              32'd100000000
`define DIPHASE_HALF_16K    32'd3125
`define DIPHASE_HALF_32K    32'd1562
`define PHASE_BAD_LIMIT     4'h3
`endif

// file: verilog/line_codec_pkg.sv
// types for the tactical line mode codec
package line_codec_pkg;
    typedef enum logic [1:0] {
        mode_normal,
        mode_separate,
        mode_comb16,
        mode_comb32
    } line_mode_t;
endpackage : line_codec_pkg

// file: verilog/sync2.sv
// two flip-flop synchroniser with edge detection on the settled level
`timescale 1ns/1ps
module sync2 (
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    input  wire logic async_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic meta_reg;
    logic stage_reg;
    logic prev_reg;

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            meta_reg  <= 1'b0;
            stage_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            meta_reg  <= async_in;
            stage_reg <= meta_reg;
            prev_reg  <= stage_reg;
        end
    end

    assign level_out = stage_reg;
    assign rise_out  = stage_reg & ~prev_reg;
    assign fall_out  = ~stage_reg & prev_reg;
endmodule : sync2

// file: verilog/tactical_line_mode_codec.sv
// line coder/decoder for separate-clock (ALTERNATE_MARK_INVERSION) and combined-clock (diphase) modes
`timescale 1ns/1ps
`include "line_codec_defs.svh"
module tactical_line_mode_codec #(
    parameter int HALF_16K = `DIPHASE_HALF_16K,
    parameter int HALF_32K = `DIPHASE_HALF_32K
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        strap_sep_n_in,
    input  wire logic        strap_comb_n_in,
    input  wire logic        tx_clock_internal_in,
    input  wire logic        internal_clock_in,
    input  wire logic [11:0] rate_kbps_in,
    input  wire logic        terminal_tx_clock_in,
    input  wire logic        tx_line_pos_in,
    input  wire logic        tx_line_neg_in,
    input  wire logic        comb_line_in,
    input  wire logic        rx_data_in,
    input  wire logic        rx_bit_clock_in,
    output logic             tx_bit_out,
    output logic             tx_bit_valid_out,
    output logic             rx_clock_out,
    output logic             rx_line_pos_out,
    output logic             rx_line_neg_out,
    output logic             internal_tx_clock_out,
    output logic             comb_line_out,
    output logic             data_phase_warning_out,
    output logic             config_error_out,
    output logic [1:0]       mode_out
);
    line_codec_pkg::line_mode_t mode_reg;
    logic init_reg;

    logic ttc_lvl, ttc_rise, ttc_fall;
    logic pos_lvl, neg_lvl, comb_lvl, comb_rise, comb_fall;
    logic icl_lvl, rxc_lvl, rxc_rise, rxc_fall, rxd_lvl;
    logic sep_n_lvl, comb_n_lvl;

    // every outside signal except rst_n_in, rate_kbps_in and tx_clock_internal_in settles through two flip-flops before use
    sync2 u_ttc (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .async_in(terminal_tx_clock_in),
                 .level_out(ttc_lvl), .rise_out(ttc_rise), .fall_out(ttc_fall));
    sync2 u_pos (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .async_in(tx_line_pos_in),
                 .level_out(pos_lvl), .rise_out(), .fall_out());
    sync2 u_neg (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .async_in(tx_line_neg_in),
                 .level_out(neg_lvl), .rise_out(), .fall_out());
    sync2 u_cmb (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .async_in(comb_line_in),
                 .level_out(comb_lvl), .rise_out(comb_rise), .fall_out(comb_fall));
    sync2 u_icl (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .async_in(internal_clock_in),
                 .level_out(icl_lvl), .rise_out(), .fall_out());
    sync2 u_rxc (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .async_in(rx_bit_clock_in),
                 .level_out(rxc_lvl), .rise_out(rxc_rise), .fall_out(rxc_fall));
    sync2 u_rxd (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .async_in(rx_data_in),
                 .level_out(rxd_lvl), .rise_out(), .fall_out());
    sync2 u_sp1 (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .async_in(strap_sep_n_in),
                 .level_out(sep_n_lvl), .rise_out(), .fall_out());
    sync2 u_sp2 (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .async_in(strap_comb_n_in),
                 .level_out(comb_n_lvl), .rise_out(), .fall_out());

    // straps are caught once, a few cycles after reset so the synchronisers have settled
    logic [1:0] strap_wait_reg;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            mode_reg       <= line_codec_pkg::mode_normal;
            init_reg       <= 1'b1;
            strap_wait_reg <= 2'h0;
        end else if (init_reg) begin
            strap_wait_reg <= strap_wait_reg + 2'h1;
            if (strap_wait_reg == 2'h3) begin
                init_reg <= 1'b0;
                unique case ({~sep_n_lvl, ~comb_n_lvl})
                    2'b10:   mode_reg <= line_codec_pkg::mode_separate;
                    2'b01:   mode_reg <= line_codec_pkg::mode_comb16;
                    2'b11:   mode_reg <= line_codec_pkg::mode_comb32;
                    2'b00:   mode_reg <= line_codec_pkg::mode_normal;
                endcase
            end
        end
    end

    wire sep_mode  = (mode_reg == line_codec_pkg::mode_separate);
    wire comb_mode = (mode_reg == line_codec_pkg::mode_comb16)
                   | (mode_reg == line_codec_pkg::mode_comb32);

    // separate-clock tx: ternary line decoded to bits, sampled on chosen clock edge
    logic sample_fall_reg;
    logic sample_edge;
    logic [3:0] marg_cnt_reg;
    logic prev_pos_reg, prev_neg_reg;
    assign sample_edge = sample_fall_reg ? ttc_fall : ttc_rise;

    // the line must hold still around the sampling edge; a change just before four sampling edges in a row
    // means we sample near a transition, so move to the opposite edge
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            prev_pos_reg           <= 1'b0;
            prev_neg_reg           <= 1'b0;
            sample_fall_reg        <= 1'b0;
            marg_cnt_reg           <= 4'h0;
            data_phase_warning_out <= 1'b0;
        end else begin
            prev_pos_reg           <= pos_lvl;
            prev_neg_reg           <= neg_lvl;
            data_phase_warning_out <= 1'b0;
            if (sep_mode && sample_edge) begin
                if ((pos_lvl != prev_pos_reg) || (neg_lvl != prev_neg_reg)) begin
                    if (marg_cnt_reg == `PHASE_BAD_LIMIT) begin
                        sample_fall_reg        <= ~sample_fall_reg;
                        data_phase_warning_out <= 1'b1;
                        marg_cnt_reg           <= 4'h0;
                    end else begin
                        marg_cnt_reg <= marg_cnt_reg + 4'h1;
                    end
                end else begin
                    marg_cnt_reg <= 4'h0;
                end
            end
        end
    end

    // combined-clock rx of terminal line: diphase, transition at every bit boundary,
    // mid-bit transition marks a one
    // 14 bits: a whole 16k bit spans more than 6000 cycles and must not saturate early
    logic [13:0] gap_reg;
    logic [13:0] half_len;
    logic        mid_seen_reg;
    assign half_len = (mode_reg == line_codec_pkg::mode_comb32) ? HALF_32K[13:0] : HALF_16K[13:0];

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            tx_bit_out       <= 1'b0;
            tx_bit_valid_out <= 1'b0;
            gap_reg          <= 14'h0000;
            mid_seen_reg     <= 1'b0;
        end else begin
            tx_bit_valid_out <= 1'b0;
            if (sep_mode && sample_edge) begin
                tx_bit_out       <= pos_lvl | neg_lvl;
                tx_bit_valid_out <= 1'b1;
            end else if (comb_mode) begin
                if (comb_rise || comb_fall) begin
                    gap_reg <= 14'h0000;
                    // short gap: one half of a one, the second half emits it; long gap: full bit
                    if (gap_reg < half_len + (half_len >> 1)) begin
                        if (mid_seen_reg) begin
                            tx_bit_out       <= 1'b1;
                            tx_bit_valid_out <= 1'b1;
                            mid_seen_reg     <= 1'b0;
                        end else begin
                            mid_seen_reg <= 1'b1;
                        end
                    end else begin
                        tx_bit_out       <= 1'b0;
                        tx_bit_valid_out <= 1'b1;
                        mid_seen_reg     <= 1'b0;
                    end
                end else if (gap_reg != 14'h3fff) begin
                    gap_reg <= gap_reg + 14'h0001;
                end
            end
        end
    end

    // separate-clock rx: ALTERNATE_MARK_INVERSION coder clocked by the modem rx clock, clock passed out apart
    logic last_pol_reg;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            rx_line_pos_out <= 1'b0;
            rx_line_neg_out <= 1'b0;
            last_pol_reg    <= 1'b0;
            rx_clock_out    <= 1'b0;
        end else begin
            rx_clock_out <= sep_mode & rxc_lvl;
            if (!sep_mode) begin
                rx_line_pos_out <= 1'b0;
                rx_line_neg_out <= 1'b0;
            end else if (rxc_fall) begin
                if (rxd_lvl) begin
                    rx_line_pos_out <= ~last_pol_reg;
                    rx_line_neg_out <= last_pol_reg;
                    last_pol_reg    <= ~last_pol_reg;
                end else begin
                    rx_line_pos_out <= 1'b0;
                    rx_line_neg_out <= 1'b0;
                end
            end
        end
    end

    // internal tx clock out and combined-clock diphase encoder
    // rx_bit_clock_in is free-running, so 's rate span is only bounded by sampling
    logic rx_half_reg;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            internal_tx_clock_out <= 1'b0;
            comb_line_out         <= 1'b0;
            rx_half_reg           <= 1'b0;
        end else begin
            internal_tx_clock_out <= sep_mode & tx_clock_internal_in & icl_lvl;
            if (comb_mode && rxc_rise) begin
                comb_line_out <= ~comb_line_out;
                rx_half_reg   <= rxd_lvl;
            end else if (comb_mode && rxc_fall && rx_half_reg) begin
                comb_line_out <= ~comb_line_out;
            end
        end
    end

    // in the combined modes only rates outside 16..32 flag; 20 passes though the link will not run
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            config_error_out <= 1'b0;
            mode_out         <= 2'h0;
        end else begin
            config_error_out <= comb_mode && ((rate_kbps_in < `RATE_16K_BPS)
                                || (rate_kbps_in > `RATE_32K_BPS));
            mode_out         <= mode_reg;
        end
    end
endmodule : tactical_line_mode_codec

// file: bench/tactical_line_mode_codec_props.sv
// port checks for the line mode codec
`timescale 1ns/1ps
`include "line_codec_defs.svh"
module tactical_line_mode_codec_props #(
    parameter int HALF_16K = `DIPHASE_HALF_16K,
    parameter int HALF_32K = `DIPHASE_HALF_32K
) (
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic [11:0] rate_kbps_in,
    input wire logic        rx_line_pos_out,
    input wire logic        rx_line_neg_out,
    input wire logic        internal_tx_clock_out,
    input wire logic        comb_line_out,
    input wire logic        data_phase_warning_out,
    input wire logic        config_error_out,
    input wire logic [1:0]  mode_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic seen_reg;
    logic pos_reg;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            seen_reg <= 1'b0;
            pos_reg  <= 1'b0;
        end else if (rx_line_pos_out || rx_line_neg_out) begin
            seen_reg <= 1'b1;
            pos_reg  <= rx_line_pos_out;
        end
    end
    sequence bad_rate_s;
        mode_out[1] && (rate_kbps_in < `RATE_16K_BPS || rate_kbps_in > `RATE_32K_BPS);
    endsequence
    sequence ok_rate_s;
        !mode_out[1] || (rate_kbps_in >= `RATE_16K_BPS && rate_kbps_in <= `RATE_32K_BPS);
    endsequence
    chk_mode_held: assert property (mode_out != 2'h0 |=> $stable(mode_out))
        else $error("mode changed after reset");
    chk_rate_error: assert property (bad_rate_s [*3] |-> config_error_out)
        else $error("missing configuration error");
    chk_rate_quiet: assert property (ok_rate_s [*3] |-> !config_error_out)
        else $error("spurious configuration error");
    chk_warn_pulse: assert property (data_phase_warning_out |=> !data_phase_warning_out)
        else $error("warning longer than one cycle");
    chk_warn_mode: assert property (data_phase_warning_out |-> mode_out == 2'h1)
        else $error("warning outside separate mode");
    chk_ami_idle: assert property (mode_out != 2'h1 |-> !(rx_line_pos_out || rx_line_neg_out))
        else $error("mark outside separate mode");
    chk_pos_alt: assert property ($rose(rx_line_pos_out) |-> !seen_reg || !pos_reg)
        else $error("two positive marks in a row");
    chk_neg_alt: assert property ($rose(rx_line_neg_out) |-> seen_reg && pos_reg)
        else $error("negative mark without positive before");
    chk_int_gate: assert property ($rose(internal_tx_clock_out) |-> mode_out == 2'h1)
        else $error("internal clock outside separate mode");
    chk_comb_idle: assert property (!mode_out[1] |-> !comb_line_out)
        else $error("diphase line active outside combined mode");
endmodule : tactical_line_mode_codec_props
bind tactical_line_mode_codec tactical_line_mode_codec_props #(
    .HALF_16K(HALF_16K), .HALF_32K(HALF_32K)) props_inst (.*);

// file: bench/terminal_model.sv
// terminal equipment: tx clock and ami data from one timing source
`timescale 1ns/1ps
module terminal_model (
    input  wire logic bad_phase_in,
    output logic      tx_clock_out = 1'b0,
    output logic      pos_out = 1'b0,
    output logic      neg_out = 1'b0
);
    logic mark_pos_reg = 1'b0;
    task automatic put_mark(input logic b);
        pos_out = b && !mark_pos_reg;
        neg_out = b && mark_pos_reg;
        if (b) mark_pos_reg = !mark_pos_reg;
    endtask : put_mark
    // clock rests low between bits; bad phase moves data into the clock edge's own cycle
    task automatic send_bit(input logic b);
        if (!bad_phase_in) put_mark(b);
        #60.5;
        if (bad_phase_in) put_mark(b);
        #2 tx_clock_out = 1'b1;
        #62.5 tx_clock_out = 1'b0;
    endtask : send_bit
endmodule : terminal_model

// file: bench/tactical_line_mode_codec_test.sv
// self-checking bench for the line mode codec
`timescale 1ns/1ps
module tactical_line_mode_codec_test;
    logic        core_clk_in = 1'b0, rst_n_in = 1'b0, strap_sep_n_in = 1'b1;
    logic        strap_comb_n_in = 1'b1, tx_clock_internal_in = 1'b0, internal_clock_in = 1'b0;
    logic [11:0] rate_kbps_in = 12'h010, rates [5] = '{12'h8, 12'h10, 12'h14, 12'h20, 12'h28};
    logic        terminal_tx_clock_in, tx_line_pos_in, tx_line_neg_in, comb_line_in = 1'b0;
    logic        rx_data_in = 1'b0, rx_bit_clock_in = 1'b0, tx_bit_out, tx_bit_valid_out;
    logic        rx_clock_out, rx_line_pos_out, rx_line_neg_out, internal_tx_clock_out;
    logic        comb_line_out, data_phase_warning_out, config_error_out, b, mark_pos;
    logic [1:0]  mode_out, exp_mark;
    logic        bad = 1'b0, track = 1'b1, comb_prev = 1'b0, exp_q[$];
    int          errors = 0, checks = 0, warns = 0, toggles = 0, int_high = 0, ones, i, k, h;
    integer      seed = 32'h80782e5c;
    always #5 core_clk_in = ~core_clk_in;
    tactical_line_mode_codec #(.HALF_16K(20), .HALF_32K(10)) tactical_line_mode_codec_inst (.*);
    terminal_model terminal_model_inst (
        .bad_phase_in (bad),
        .tx_clock_out (terminal_tx_clock_in),
        .pos_out      (tx_line_pos_in),
        .neg_out      (tx_line_neg_in)
    );
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic complete_run();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : cycles
    task automatic rx_bit(input logic v);
        @(posedge core_clk_in);
        rx_data_in <= v;
        rx_bit_clock_in <= 1'b1;
        cycles(8);
        chk("rx_clk", {11'h0, i == 1}, {11'h0, rx_clock_out});
        rx_bit_clock_in <= 1'b0;
        cycles(8);
        #1;
        exp_mark = (i == 1 && v) ? (mark_pos ? 2'b01 : 2'b10) : 2'b00;
        if (i == 1 && v) mark_pos = !mark_pos;
        chk("rx_mark", {10'h0, exp_mark}, {10'h0, rx_line_pos_out, rx_line_neg_out});
        chk("rx_clk_low", 12'h0, {11'h0, rx_clock_out});
    endtask : rx_bit
    task automatic tx_bit(input logic v);
        if (track && i == 1) exp_q.push_back(v);
        terminal_model_inst.send_bit(v);
    endtask : tx_bit
    // one diphase bit: optional mid-bit edge, closing boundary edge, h cycles per half
    task automatic comb_bit(input logic v);
        if (i[1]) exp_q.push_back(v);
        if (v) comb_line_in <= ~comb_line_in;
        cycles(h);
        comb_line_in <= ~comb_line_in;
        cycles(h);
    endtask : comb_bit
    always @(posedge core_clk_in) begin
        if (tx_bit_valid_out === 1'b1 && track) begin
            if (exp_q.size() == 0) chk("tx_extra", 12'h0, 12'h1);
            else chk("tx_bit", {11'h0, exp_q.pop_front()}, {11'h0, tx_bit_out});
        end
        if (data_phase_warning_out === 1'b1) warns++;
        if (comb_line_out !== comb_prev) toggles++;
        comb_prev = comb_line_out;
        if (internal_tx_clock_out === 1'b1) int_high++;
    end
    initial begin
        for (i = 0; i < 4; i++) begin
            @(posedge core_clk_in);
            rst_n_in <= 1'b0;
            strap_sep_n_in <= !i[0];
            strap_comb_n_in <= !i[1];
            cycles(12);
            rst_n_in <= 1'b1;
            cycles(8);
            mark_pos = 1'b0;
            warns = 0;
            chk("mode", i[11:0], {10'h0, mode_out});
            for (k = 0; k < 5; k++) begin
                rate_kbps_in <= rates[k];
                cycles(4);
                b = i[1] && (rates[k] < 12'h10 || rates[k] > 12'h20);
                chk("cfg_err", {11'h0, b}, {11'h0, config_error_out});
            end
            toggles = 0;
            ones = 0;
            for (k = 0; k < 6; k++) begin
                b = 1'($random(seed));
                ones += b;
                rx_bit(b);
            end
            chk("toggles", i[1] ? 12'(6 + ones) : 12'h0, toggles[11:0]);
            h = i[0] ? 10 : 20;
            if (i != 1) begin
                // the opening edge after a long idle line reads as a zero, so it is not tracked
                track = 1'b0;
                comb_line_in <= ~comb_line_in;
                cycles(6);
                track = 1'b1;
                cycles(h - 6);
                for (k = 0; k < 6; k++) comb_bit(1'($random(seed)));
            end
            for (k = 0; k < 8; k++) tx_bit(1'($random(seed)));
            cycles(10);
            chk("tx_left", 12'h0, 12'(exp_q.size()));
            chk("warn_good", 12'h0, warns[11:0]);
            if (i == 1) begin
                bad = 1'b1;
                track = 1'b0;
                for (k = 0; k < 8; k++) tx_bit(!k[0]);
                #300;
                chk("warn_once", 12'h1, warns[11:0]);
                track = 1'b1;
                for (k = 0; k < 6; k++) tx_bit(1'($random(seed)));
                cycles(10);
                chk("tx_flip", 12'h0, 12'(exp_q.size()));
                bad = 1'b0;
            end
            for (k = 0; k < 2; k++) begin
                tx_clock_internal_in <= k[0];
                int_high = 0;
                repeat (20) begin
                    cycles(2);
                    internal_clock_in <= ~internal_clock_in;
                end
                chk("int_clk", {11'h0, i == 1 && k == 1}, {11'h0, int_high != 0});
            end
            tx_clock_internal_in <= 1'b0;
        end
        strap_sep_n_in <= 1'b1;
        strap_comb_n_in <= 1'b1;
        cycles(10);
        chk("mode_kept", 12'h3, {10'h0, mode_out});
        complete_run();
    end
    initial begin
        #100000;
        errors++;
        complete_run();
    end
endmodule : tactical_line_mode_codec_test
